// [rtl/cca_pkg.sv]
// package: register indices, field positions and timing for the counter array
package cca_pkg;
  localparam int ModuleCount = 5;
  localparam int FirstPinBit = 3;
  localparam int ExtCountPinBit = 2;
  // register indices; byte address is four times the index
  localparam logic [9:0] ControlIdx = 10'h0d8;
  localparam logic [9:0] ModeIdx = 10'h0d9;
  localparam logic [9:0] ModuleModeIdx = 10'h0da;
  localparam logic [9:0] CountLowIdx = 10'h0e0;
  localparam logic [9:0] CountHighIdx = 10'h0e1;
  localparam logic [9:0] ValueLowIdx = 10'h0e2;
  localparam logic [9:0] ValueHighIdx = 10'h0e7;
  // counter_control fields
  localparam int OverflowFlagBit = 7;
  localparam int RunControlBit = 6;
  // counter_mode fields
  localparam int IdleGateBit = 7;
  localparam int WatchdogEnBit = 6;
  localparam int SourceSelLoBit = 1;
  localparam int OverflowIrqEnBit = 0;
  // module_mode fields
  localparam int ModuleIrqEnBit = 0;
  localparam int PwmModeBit = 1;
  localparam int FlipOnHitBit = 2;
  localparam int HitFlagEnBit = 3;
  localparam int FallingCapBit = 4;
  localparam int RisingCapBit = 5;
  localparam int ComparatorEnBit = 6;
  // reset values and writable masks
  localparam logic [7:0] ControlReset = 8'h00;
  localparam logic [7:0] ModeReset = 8'h00;
  localparam logic [7:0] ModuleModeReset = 8'h00;
  localparam logic [7:0] ValueReset = 8'h00;
  localparam logic [15:0] CountReset = 16'h0000;
  localparam logic [7:0] ModeWriteMask = 8'hc7;
  localparam logic [7:0] ModuleModeWriteMask = 8'h7f;
  // oscillator prescale
  localparam int OscDivide = 6;
  localparam logic [2:0] PrescaleLast = 3'(OscDivide - 1);
  typedef enum logic [1:0] {
    SrcOscA = 2'b00,
    SrcOscB = 2'b01,
    SrcTimer0 = 2'b10,
    SrcExternal = 2'b11
  } count_source_t;
endpackage : cca_pkg

// [rtl/counter_array_capture_compare.sv]
// counter array: shared 16-bit counter and five capture/compare modules
// Operation
// - one 16-bit counter feeds five modules
// - module n uses port bit 3+n
// - counter bytes readable, live, count up
// - source select: osc/6, timer0, external pin
// - idle gate stops counter during idle
// - mode bit 6 enables module-4 watchdog
// - overflow irq enable gates overflow request
// - run control bit starts and stops counter
// - overflow flag set by hw, sw clears
// - module flags set on hit or capture
// - all flags share one request line
// - module irq enable gates its flag
// - module mode bit 1 selects pulse width
// - flip-on-hit inverts pin on compare hit
// - hit flag enable sets flag on hit
// - capture on falling, rising or both edges
// - comparator enable arms the compare
// - value registers capture counter, hold compare
// - pwm pin high once low byte reaches value
// - pwm low value reloads at byte wrap
`timescale 1ns/100ps
`default_nettype none
module counter_array_capture_compare (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpuIdle,
  input wire logic timer0Overflow,
  input wire logic [7:0] port1PinIn,
  output logic [7:0] port1PinOut,
  output logic [7:0] port1PinOeN,
  output logic irqRequest,
  output logic module4WatchdogEnable
);
  localparam int N = cca_pkg::ModuleCount;
  localparam logic [9:0] ModW = 10'(cca_pkg::ModuleCount);

  logic [9:0] idx;
  logic aligned;
  logic wrEn;
  logic accessReadyQ;
  logic mapped;
  logic [7:0] rdData;
  logic [9:0] offMode;
  logic [9:0] offLow;
  logic [9:0] offHigh;
  logic ctlWr;
  logic overflowFlagQ;
  logic runControlQ;
  logic [N-1:0] eventFlagsQ;
  logic [N-1:0] eventSet;
  logic [N-1:0] irqEnVec;
  logic [7:0] modeQ;
  logic [15:0] counterQ;
  logic [15:0] cntNext;
  logic [2:0] prescaleQ;
  logic [2:0] extSyncQ;
  logic extLevelQ;
  logic extFall;
  logic srcPulse;
  logic runGate;
  logic tick;
  logic overflow;
  logic wrap8;
  logic [7:0] modeArr [N];
  logic [7:0] loArr [N];
  logic [7:0] hiArr [N];
  logic [N-1:0] outQ;
  logic [N-1:0] oeNQ;
  cca_pkg::count_source_t srcSel;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // apb slave: data latched in setup, answer in first access cycle
  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign pready = psel & penable & accessReadyQ & clkEn;
  assign wrEn = pready & pwrite;
  assign offMode = idx - cca_pkg::ModuleModeIdx;
  assign offLow = idx - cca_pkg::ValueLowIdx;
  assign offHigh = idx - cca_pkg::ValueHighIdx;

  always_comb begin
    rdData = 8'h00;
    mapped = 1'b1;
    if (!aligned) begin
      mapped = 1'b0;
    end else if (idx == cca_pkg::ControlIdx) begin
      rdData = {overflowFlagQ, runControlQ, 1'b0, eventFlagsQ};
    end else if (idx == cca_pkg::ModeIdx) begin
      rdData = modeQ;
    end else if (offMode < ModW) begin
      rdData = modeArr[offMode[2:0]];
    end else if (idx == cca_pkg::CountLowIdx) begin
      rdData = counterQ[7:0];
    end else if (idx == cca_pkg::CountHighIdx) begin
      rdData = counterQ[15:8];
    end else if (offLow < ModW) begin
      rdData = loArr[offLow[2:0]];
    end else if (offHigh < ModW) begin
      rdData = hiArr[offHigh[2:0]];
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      accessReadyQ <= 1'b0;
    end else if (clkEn) begin
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdData};
        pslverr <= ~mapped;
        accessReadyQ <= 1'b1;
      end else if (pready) begin
        accessReadyQ <= 1'b0;
      end
    end
  end

  // counter mode register
  always_ff @(posedge clk) begin
    if (rst) begin
      modeQ <= cca_pkg::ModeReset;
    end else if (clkEn && wrEn && idx == cca_pkg::ModeIdx) begin
      modeQ <= pwdata[7:0] & cca_pkg::ModeWriteMask;
    end
  end

  assign module4WatchdogEnable = modeQ[cca_pkg::WatchdogEnBit];

  // external count pin: three flops, change once last two agree
  always_ff @(posedge clk) begin
    if (rst) begin
      extSyncQ <= 3'h0;
      extLevelQ <= 1'b0;
    end else if (clkEn) begin
      extSyncQ <= {extSyncQ[1:0], port1PinIn[cca_pkg::ExtCountPinBit]};
      if (extSyncQ[1] == extSyncQ[2]) begin
        extLevelQ <= extSyncQ[2];
      end
    end
  end

  assign extFall = ~extSyncQ[1] & ~extSyncQ[2] & extLevelQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      prescaleQ <= 3'h0;
    end else if (clkEn) begin
      if (prescaleQ == cca_pkg::PrescaleLast) begin
        prescaleQ <= 3'h0;
      end else begin
        prescaleQ <= prescaleQ + 3'h1;
      end
    end
  end

  assign srcSel = cca_pkg::count_source_t'(
    modeQ[cca_pkg::SourceSelLoBit +: 2]);

  always_comb begin
    case (srcSel)
      cca_pkg::SrcTimer0: srcPulse = timer0Overflow;
      cca_pkg::SrcExternal: srcPulse = extFall;
      default: srcPulse = (prescaleQ == cca_pkg::PrescaleLast);
    endcase
  end

  assign runGate = runControlQ
    & ~(modeQ[cca_pkg::IdleGateBit] & cpuIdle);
  assign tick = clkEn & runGate & srcPulse;
  assign cntNext = counterQ + 16'h0001;
  assign overflow = tick & (counterQ == 16'hffff);
  assign wrap8 = tick & (counterQ[7:0] == 8'hff);

  // shared up counter, software may load either byte
  always_ff @(posedge clk) begin
    if (rst) begin
      counterQ <= cca_pkg::CountReset;
    end else if (clkEn) begin
      if (wrEn && idx == cca_pkg::CountLowIdx) begin
        counterQ[7:0] <= pwdata[7:0];
      end else if (wrEn && idx == cca_pkg::CountHighIdx) begin
        counterQ[15:8] <= pwdata[7:0];
      end else if (tick) begin
        counterQ <= cntNext;
      end
    end
  end

  // control flags: hardware set beats a software clear
  assign ctlWr = wrEn && (idx == cca_pkg::ControlIdx);

  always_ff @(posedge clk) begin
    if (rst) begin
      overflowFlagQ <= cca_pkg::ControlReset[cca_pkg::OverflowFlagBit];
      runControlQ <= cca_pkg::ControlReset[cca_pkg::RunControlBit];
      eventFlagsQ <= cca_pkg::ControlReset[N-1:0];
    end else if (clkEn) begin
      overflowFlagQ <= overflow
        | (ctlWr ? pwdata[cca_pkg::OverflowFlagBit] : overflowFlagQ);
      eventFlagsQ <= eventSet
        | (ctlWr ? pwdata[N-1:0] : eventFlagsQ);
      if (ctlWr) begin
        runControlQ <= pwdata[cca_pkg::RunControlBit];
      end
    end
  end

  assign irqRequest = (overflowFlagQ
    & modeQ[cca_pkg::OverflowIrqEnBit])
    | |(eventFlagsQ & irqEnVec);

  assign port1PinOut[cca_pkg::FirstPinBit-1:0] = '0;
  assign port1PinOeN[cca_pkg::FirstPinBit-1:0] = '1;

  genvar n;
  for (n = 0; n < N; n++) begin : g_mod
    logic [2:0] syncQ;
    logic levelQ;
    logic capture;
    logic hit;
    logic pwm;
    logic wrMode;
    logic wrLo;
    logic wrHi;
    logic pinQ;

    assign wrMode = wrEn && idx == 10'(cca_pkg::ModuleModeIdx + n);
    assign wrLo = wrEn && idx == 10'(cca_pkg::ValueLowIdx + n);
    assign wrHi = wrEn && idx == 10'(cca_pkg::ValueHighIdx + n);
    assign pwm = modeArr[n][cca_pkg::PwmModeBit];
    assign irqEnVec[n] = modeArr[n][cca_pkg::ModuleIrqEnBit];

    // module pin sampled through three flops
    always_ff @(posedge clk) begin
      if (rst) begin
        syncQ <= 3'h0;
        levelQ <= 1'b0;
      end else if (clkEn) begin
        syncQ <= {syncQ[1:0], port1PinIn[cca_pkg::FirstPinBit + n]};
        if (syncQ[1] == syncQ[2]) begin
          levelQ <= syncQ[2];
        end
      end
    end

    assign capture = clkEn & (
      (modeArr[n][cca_pkg::RisingCapBit]
        & syncQ[1] & syncQ[2] & ~levelQ)
      | (modeArr[n][cca_pkg::FallingCapBit]
        & ~syncQ[1] & ~syncQ[2] & levelQ));
    assign hit = modeArr[n][cca_pkg::ComparatorEnBit]
      & tick & (cntNext == {hiArr[n], loArr[n]});
    assign eventSet[n] = capture
      | (hit & modeArr[n][cca_pkg::HitFlagEnBit]);

    always_ff @(posedge clk) begin
      if (rst) begin
        modeArr[n] <= cca_pkg::ModuleModeReset;
      end else if (clkEn && wrMode) begin
        modeArr[n] <= pwdata[7:0] & cca_pkg::ModuleModeWriteMask;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        loArr[n] <= cca_pkg::ValueReset;
        hiArr[n] <= cca_pkg::ValueReset;
      end else if (clkEn) begin
        if (wrLo) begin
          loArr[n] <= pwdata[7:0];
        end else if (capture) begin
          loArr[n] <= counterQ[7:0];
        end else if (pwm && wrap8) begin
          loArr[n] <= hiArr[n];
        end
        if (wrHi) begin
          hiArr[n] <= pwdata[7:0];
        end else if (capture) begin
          hiArr[n] <= counterQ[15:8];
        end
      end
    end

    // pin drive: pwm level or toggled compare output
    always_ff @(posedge clk) begin
      if (rst) begin
        pinQ <= 1'b0;
        outQ[n] <= 1'b0;
        oeNQ[n] <= 1'b1;
      end else if (clkEn) begin
        if (hit && modeArr[n][cca_pkg::FlipOnHitBit]) begin
          pinQ <= ~pinQ;
        end
        outQ[n] <= pwm ? (counterQ[7:0] >= loArr[n]) : pinQ;
        oeNQ[n] <= ~(pwm | modeArr[n][cca_pkg::FlipOnHitBit]);
      end
    end

    assign port1PinOut[cca_pkg::FirstPinBit + n] = outQ[n];
    assign port1PinOeN[cca_pkg::FirstPinBit + n] = oeNQ[n];

    sequence s_capTaken;
      capture ##1 1'b1;
    endsequence

    property p_capture;
      s_capTaken |-> {hiArr[n], loArr[n]} == $past(counterQ);
    endproperty
    a_capture: assert property (p_capture)
      else $error("capture did not load counter value");

    property p_eventFlag;
      eventSet[n] |=> eventFlagsQ[n];
    endproperty
    a_eventFlag: assert property (p_eventFlag)
      else $error("module event flag not set");

    property p_toggle;
      hit && modeArr[n][cca_pkg::FlipOnHitBit] |=> pinQ != $past(pinQ);
    endproperty
    a_toggle: assert property (p_toggle)
      else $error("pin did not invert on hit");

    property p_reload;
      pwm && wrap8 && !wrLo && !capture |=> loArr[n] == $past(hiArr[n]);
    endproperty
    a_reload: assert property (p_reload)
      else $error("pwm low value not reloaded");

    property p_pwmLevel;
      pwm && clkEn && (counterQ[7:0] < loArr[n]) |=> !outQ[n];
    endproperty
    a_pwmLevel: assert property (p_pwmLevel)
      else $error("pwm pin high below threshold");
  end

  sequence s_overflowSeen;
    overflow ##1 overflowFlagQ;
  endsequence

  property p_overflowSet;
    overflow |-> s_overflowSeen;
  endproperty
  a_overflowSet: assert property (p_overflowSet)
    else $error("overflow flag not set");

  property p_overflowHold;
    overflowFlagQ && !ctlWr |=> overflowFlagQ;
  endproperty
  a_overflowHold: assert property (p_overflowHold)
    else $error("overflow flag cleared by hardware");

  property p_stopped;
    !runControlQ && !wrEn |=> $stable(counterQ);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped");

  property p_idle;
    modeQ[cca_pkg::IdleGateBit] && cpuIdle |-> !tick;
  endproperty
  a_idle: assert property (p_idle)
    else $error("counter ticked in gated idle");

  property p_divide;
    tick && srcSel != cca_pkg::SrcTimer0
      && srcSel != cca_pkg::SrcExternal |=> !tick [*5];
  endproperty
  a_divide: assert property (p_divide)
    else $error("oscillator tick closer than six cycles");

  property p_irqQuiet;
    !modeQ[cca_pkg::OverflowIrqEnBit] && eventFlagsQ == '0 |-> !irqRequest;
  endproperty
  a_irqQuiet: assert property (p_irqQuiet)
    else $error("interrupt request with no enabled flag");
endmodule : counter_array_capture_compare
`default_nettype wire

// [testbench/pin_partner.sv]
// partner model: drives port-1 input pins with a selectable lag
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  input wire logic clk,
  input wire logic [7:0] pinWant,
  input wire logic [3:0] lag,
  output logic [7:0] pinDrive
);
  logic [3:0] waitCnt = 4'h0;
  logic [1:0] holdCnt = 2'h0;
  initial pinDrive = 8'h00;
  always @(posedge clk) begin
    if (holdCnt != 2'h3) begin
      holdCnt <= holdCnt + 2'h1;
    end
    if (pinWant == pinDrive) begin
      waitCnt <= 4'h0;
    end else if (waitCnt < lag) begin
      waitCnt <= waitCnt + 4'h1;
    end else if (pinWant[2] == pinDrive[2] || holdCnt >= 2'h1) begin
      pinDrive <= pinWant;
      waitCnt <= 4'h0;
      if (pinWant[2] != pinDrive[2]) begin
        holdCnt <= 2'h0;
      end
    end
  end
endmodule : pin_partner
`default_nettype wire

// [testbench/counter_array_capture_compare_tb.sv]
// self-checking bench: registers over APB, counting, capture, compare, pwm
`timescale 1ns/100ps
`default_nettype none
module counter_array_capture_compare_tb;
  localparam logic [9:0] Ctl = cca_pkg::ControlIdx;
  localparam logic [9:0] Md = cca_pkg::ModeIdx;
  localparam logic [9:0] Mm = cca_pkg::ModuleModeIdx;
  localparam logic [9:0] Cl = cca_pkg::CountLowIdx;
  localparam logic [9:0] Ch = cca_pkg::CountHighIdx;
  localparam logic [9:0] Vl = cca_pkg::ValueLowIdx;
  localparam logic [9:0] Vh = cca_pkg::ValueHighIdx;
  typedef struct {
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
    logic err;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, wdog, errv;
  logic cpuIdle = 1'b0;
  logic t0 = 1'b0;
  logic [7:0] want = 8'h00;
  logic [3:0] lag = 4'h0;
  logic [7:0] drive, pinOut, oeN, rdv;
  wire logic [7:0] pinLevel = (~oeN & pinOut) | (oeN & drive);
  int n_fail = 0;
  int checked = 0;
  row_t rows [6] = '{
    '{Md, 8'hff, 8'hc7, 1'b0},
    '{Mm + 10'h4, 8'hff, 8'h7f, 1'b0},
    '{Vl + 10'h3, 8'ha5, 8'ha5, 1'b0},
    '{Vh + 10'h3, 8'h5a, 8'h5a, 1'b0},
    '{Cl, 8'h3c, 8'h3c, 1'b0},
    '{10'h0c0, 8'hff, 8'h00, 1'b1}
  };
  always #5 clk = ~clk;
  pin_partner partner (.clk(clk), .pinWant(want), .lag(lag),
    .pinDrive(drive));
  counter_array_capture_compare DUT (
    .clk(clk), .rst(rst), .clkEn(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpuIdle(cpuIdle),
    .timer0Overflow(t0), .port1PinIn(pinLevel), .port1PinOut(pinOut),
    .port1PinOeN(oeN), .irqRequest(irq), .module4WatchdogEnable(wdog)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    // pready and read data taken at the same rising edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata[7:0];
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask : wr
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    chk(rdv, e);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      t0 <= 1'b1;
      @(posedge clk);
      t0 <= 1'b0;
    end
  endtask : tick
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(oeN, 8'hff);
    chk(8'(irq), 8'h00);
    chk(8'(wdog), 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rd(rows[i].idx, rows[i].exp);
      chk(8'(errv), 8'(rows[i].err));
    end
    chk(8'(wdog), 8'h01);
    wr(Mm + 10'h4, 8'h00);
    for (int s = 0; s < 2; s++) begin
      wr(Cl, 8'h00);
      wr(Md, 8'(s * 2));
      wr(Ctl, 8'h40);
      repeat (60) @(posedge clk);
      wr(Ctl, 8'h00);
      apb(1'b0, Cl, 8'h00);
      chk(8'(rdv > 8'h08 && rdv < 8'h0d), 8'h01);
    end
    wr(Md, 8'h04);
    wr(Cl, 8'h00);
    wr(Ctl, 8'h40);
    tick(7);
    rd(Cl, 8'h07);
    cpuIdle <= 1'b1;
    wr(Md, 8'h84);
    tick(3);
    rd(Cl, 8'h07);
    cpuIdle <= 1'b0;
    tick(1);
    rd(Cl, 8'h08);
    wr(Ctl, 8'h00);
    tick(2);
    rd(Cl, 8'h08);
    wr(Ch, 8'hff);
    wr(Cl, 8'hff);
    wr(Md, 8'h05);
    wr(Ctl, 8'h40);
    tick(1);
    rd(Ctl, 8'hc0);
    rd(Cl, 8'h00);
    chk(8'(irq), 8'h01);
    wr(Md, 8'h04);
    @(negedge clk);
    chk(8'(irq), 8'h00);
    tick(2);
    rd(Ctl, 8'hc0);
    wr(Ctl, 8'h40);
    rd(Ctl, 8'h40);
    wr(Vl, 8'h07);
    wr(Vh, 8'h00);
    wr(Mm, 8'h4d);
    tick(5);
    rd(Ctl, 8'h41);
    chk(8'(irq), 8'h01);
    wt(3);
    chk(pinOut & ~oeN, 8'h08);
    wr(Mm, 8'h0c);
    @(negedge clk);
    chk(8'(irq), 8'h00);
    wr(Ctl, 8'h40);
    wr(Cl, 8'h06);
    tick(1);
    rd(Ctl, 8'h40);
    chk(pinOut & ~oeN, 8'h08);
    wr(Ctl, 8'h00);
    wr(Mm + 10'h1, 8'h20);
    wr(Ch, 8'h12);
    wr(Cl, 8'h34);
    lag <= 4'h3;
    want[4] <= 1'b1;
    wt(10);
    rd(Vl + 10'h1, 8'h34);
    rd(Vh + 10'h1, 8'h12);
    rd(Ctl, 8'h02);
    wr(Mm + 10'h1, 8'h10);
    wr(Cl, 8'h55);
    wr(Ctl, 8'h00);
    want[4] <= 1'b0;
    wt(10);
    rd(Vl + 10'h1, 8'h55);
    lag <= 4'h0;
    wr(Cl, 8'h00);
    wr(Md, 8'h06);
    wr(Ctl, 8'h40);
    repeat (4) begin
      want[2] <= 1'b1;
      wt(2);
      want[2] <= 1'b0;
      wt(2);
    end
    wt(4);
    rd(Cl, 8'h04);
    wr(Ctl, 8'h00);
    wr(Mm + 10'h2, 8'h42);
    wr(Vl + 10'h2, 8'h80);
    wr(Vh + 10'h2, 8'h10);
    wr(Cl, 8'h7f);
    wt(3);
    chk(pinOut & ~oeN, 8'h08);
    wr(Cl, 8'h80);
    wt(3);
    chk(pinOut & ~oeN, 8'h28);
    wr(Cl, 8'hff);
    wr(Md, 8'h04);
    wr(Ctl, 8'h40);
    tick(1);
    rd(Vl + 10'h2, 8'h10);
    // reset again mid-run: registers and pin enables back to idle
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(Ctl, 8'h00);
    rd(Vl + 10'h2, 8'h00);
    @(negedge clk);
    chk(oeN, 8'hff);
    report_and_stop();
  end
endmodule : counter_array_capture_compare_tb
`default_nettype wire
